/* File: logic/dtp_debug_port.v */
// debug and trace port: scan port, serial debug port, trace outputs
`timescale 1ns/1ns
`include "dtp_consts.vh"

// Contract
// - strap sampled during reset picks scan port or serial debug
// - low test reset clears scan logic asynchronously
// - mode select sampled on test clock rise advances scan controller
// - test data in sampled on test clock rise
// - test data out driven only in Shift-IR and Shift-DR
// - test data out changes only on test clock fall
// - serial output is registered, changes after clock validated high
// - breakpoint request halts core after current instruction
// - while halted, status and debug data outputs show 0xF
// - with breakpoint disable set, request raises debug interrupt
// - status clock rises mid-way through valid status data
// - trace quiesce holds status clock low and freezes data; clearing resumes
// - status clock starts at first status of 0xC, 0xD or 0xF
// - status outputs synchronous to clock, independent of bus
// - all-status output is AND of four status bits
// - debug data outputs show captured data and breakpoint status
module dtp_debug_port (
	// clock and reset
	input  wire       ref_clk_i,
	input  wire       srst_i,
	// mode strap
	input  wire       scan_mode_strap_i,
	output reg        scan_mode_o,
	// scan port pins
	input  wire       test_reset_n_i,
	input  wire       test_clock_i,
	input  wire       test_mode_sel_i,
	input  wire       test_data_in_i,
	output reg        test_data_out_o,
	output reg        test_data_out_oe_o,
	// serial debug pins
	input  wire       debug_serial_clock_i,
	input  wire       debug_serial_in_i,
	output reg        debug_serial_out_o,
	// received debug words
	output wire [7:0] dbg_rx_data_o,
	output wire       dbg_rx_valid_o,
	input  wire       dbg_rx_ready_i,
	output reg        dbg_rx_overrun_o,
	// response debug words
	input  wire [7:0] dbg_tx_data_i,
	input  wire       dbg_tx_valid_i,
	output reg        dbg_tx_ready_o,
	// breakpoint and core handshake
	input  wire       breakpoint_request_i,
	input  wire       breakpoint_disable_i,
	input  wire       core_instr_done_i,
	input  wire       core_resume_i,
	output reg        core_halt_o,
	output reg        debug_irq_o,
	// core trace sources
	input  wire [3:0] core_status_i,
	input  wire [3:0] core_ddata_i,
	input  wire       trace_quiesce_i,
	// trace pins
	output reg  [3:0] processor_status_o,
	output reg  [3:0] debug_data_out_o,
	output reg  [7:0] status_debug_data_o,
	output reg        all_status_and_o,
	output reg        status_clock_o
);
	// ********************************
	// pin synchronisers
	// ********************************
	wire [6:0] pin_lvl;
	wire       tck_lvl;
	wire       tms_lvl;
	wire       tdi_lvl;
	wire       strap_lvl;
	wire       debug_serial_clock_lvl;
	wire       dsi_lvl;
	wire       breakpoint_request_lvl;

	dtp_sync3 #(
		.W(7)
	) u_sync (
		.ref_clk_i (ref_clk_i),
		.srst_i    (srst_i),
		.pin_i     ({breakpoint_request_i, debug_serial_in_i,
			debug_serial_clock_i, scan_mode_strap_i,
			test_data_in_i, test_mode_sel_i, test_clock_i}),
		.level_o   (pin_lvl)
	);

	assign tck_lvl   = pin_lvl[0];
	assign tms_lvl   = pin_lvl[1];
	assign tdi_lvl   = pin_lvl[2];
	assign strap_lvl = pin_lvl[3];
	assign debug_serial_clock_lvl = pin_lvl[4];
	assign dsi_lvl   = pin_lvl[5];
	assign breakpoint_request_lvl  = pin_lvl[6];

	// ********************************
	// mode strap
	// ********************************
	// strap caught while reset held
	always @(posedge ref_clk_i) begin
		if (srst_i) begin
			scan_mode_o <= strap_lvl;
		end
	end

	// ********************************
	// scan controller
	// ********************************
	function [3:0] tap_next;
		input [3:0] st;
		input       tms;
		begin
			case (st)
			`DTP_TAP_RESET:    tap_next = tms ? `DTP_TAP_RESET
				: `DTP_TAP_IDLE;
			`DTP_TAP_IDLE:     tap_next = tms ? `DTP_TAP_SEL_DR
				: `DTP_TAP_IDLE;
			`DTP_TAP_SEL_DR:   tap_next = tms ? `DTP_TAP_SEL_IR
				: `DTP_TAP_CAP_DR;
			`DTP_TAP_CAP_DR:   tap_next = tms ? `DTP_TAP_EXIT1_DR
				: `DTP_TAP_SHIFT_DR;
			`DTP_TAP_SHIFT_DR: tap_next = tms ? `DTP_TAP_EXIT1_DR
				: `DTP_TAP_SHIFT_DR;
			`DTP_TAP_EXIT1_DR: tap_next = tms ? `DTP_TAP_UPD_DR
				: `DTP_TAP_PAUSE_DR;
			`DTP_TAP_PAUSE_DR: tap_next = tms ? `DTP_TAP_EXIT2_DR
				: `DTP_TAP_PAUSE_DR;
			`DTP_TAP_EXIT2_DR: tap_next = tms ? `DTP_TAP_UPD_DR
				: `DTP_TAP_SHIFT_DR;
			`DTP_TAP_UPD_DR:   tap_next = tms ? `DTP_TAP_SEL_DR
				: `DTP_TAP_IDLE;
			`DTP_TAP_SEL_IR:   tap_next = tms ? `DTP_TAP_RESET
				: `DTP_TAP_CAP_IR;
			`DTP_TAP_CAP_IR:   tap_next = tms ? `DTP_TAP_EXIT1_IR
				: `DTP_TAP_SHIFT_IR;
			`DTP_TAP_SHIFT_IR: tap_next = tms ? `DTP_TAP_EXIT1_IR
				: `DTP_TAP_SHIFT_IR;
			`DTP_TAP_EXIT1_IR: tap_next = tms ? `DTP_TAP_UPD_IR
				: `DTP_TAP_PAUSE_IR;
			`DTP_TAP_PAUSE_IR: tap_next = tms ? `DTP_TAP_EXIT2_IR
				: `DTP_TAP_PAUSE_IR;
			`DTP_TAP_EXIT2_IR: tap_next = tms ? `DTP_TAP_UPD_IR
				: `DTP_TAP_SHIFT_IR;
			`DTP_TAP_UPD_IR:   tap_next = tms ? `DTP_TAP_SEL_DR
				: `DTP_TAP_IDLE;
			default:           tap_next = `DTP_TAP_RESET;
			endcase
		end
	endfunction

	reg  [3:0] tap_reg;
	reg  [3:0] ir_reg;
	reg  [3:0] ir_sh_reg;
	reg  [3:0] dr_sh_reg;
	reg        bypass_reg;
	reg        tck_prev_reg;
	wire       tck_rise;
	wire       tck_fall;
	wire       tap_hold;
	wire       dr_out;

	assign tck_rise = tck_lvl & ~tck_prev_reg;
	assign tck_fall = ~tck_lvl & tck_prev_reg;
	// scan logic parked while strap selects serial debug
	assign tap_hold = srst_i | ~scan_mode_o;
	assign dr_out   = (ir_reg == `DTP_IR_STATUS) ? dr_sh_reg[0] : bypass_reg;

	always @(posedge ref_clk_i or negedge test_reset_n_i) begin
		if (!test_reset_n_i) begin
			tap_reg            <= `DTP_TAP_RESET;
			ir_reg             <= `DTP_IR_BYPASS;
			ir_sh_reg          <= 4'h0;
			dr_sh_reg          <= 4'h0;
			bypass_reg         <= 1'b0;
			tck_prev_reg       <= 1'b0;
			test_data_out_o    <= 1'b0;
			test_data_out_oe_o <= 1'b0;
		end else if (tap_hold) begin
			tap_reg            <= `DTP_TAP_RESET;
			ir_reg             <= `DTP_IR_BYPASS;
			tck_prev_reg       <= tck_lvl;
			test_data_out_o    <= 1'b0;
			test_data_out_oe_o <= 1'b0;
		end else begin
			tck_prev_reg <= tck_lvl;
			if (tck_rise) begin
				tap_reg <= tap_next(tap_reg, tms_lvl);
				// data in taken on rising edge
				case (tap_reg)
				`DTP_TAP_RESET:    ir_reg <= `DTP_IR_BYPASS;
				`DTP_TAP_CAP_IR:   ir_sh_reg <= `DTP_IR_CAPTURE;
				`DTP_TAP_SHIFT_IR: ir_sh_reg <= {tdi_lvl, ir_sh_reg[3:1]};
				`DTP_TAP_UPD_IR:   ir_reg <= ir_sh_reg;
				`DTP_TAP_CAP_DR: begin
					bypass_reg <= 1'b0;
					dr_sh_reg  <= {core_halt_o, breakpoint_disable_i,
						trace_quiesce_i, scan_mode_o};
				end
				`DTP_TAP_SHIFT_DR: begin
					bypass_reg <= tdi_lvl;
					dr_sh_reg  <= {tdi_lvl, dr_sh_reg[3:1]};
				end
				default: begin
					bypass_reg <= bypass_reg;
				end
				endcase
			end
			// output moves on falling edge only
			if (tck_fall) begin
				test_data_out_oe_o <= (tap_reg == `DTP_TAP_SHIFT_IR) ||
					(tap_reg == `DTP_TAP_SHIFT_DR);
				test_data_out_o    <= (tap_reg == `DTP_TAP_SHIFT_IR) ?
					ir_sh_reg[0] : dr_out;
			end
		end
	end

	// ********************************
	// serial debug port
	// ********************************
	reg  [7:0] rx_sh_reg;
	reg  [7:0] tx_sh_reg;
	reg  [7:0] tx_hold_reg;
	reg  [7:0] rx_hold_reg;
	reg        rx_hold_v_reg;
	reg  [2:0] bit_cnt_reg;
	reg        debug_serial_clock_prev_reg;
	wire       debug_serial_clock_rise;
	wire       word_done;
	wire       buf_in_ready;
	wire       ser_hold;

	// serial port idle while strap selects scan port
	assign ser_hold   = srst_i | scan_mode_o;
	// host keeps clock slow enough for this detector
	assign debug_serial_clock_rise = debug_serial_clock_lvl & ~debug_serial_clock_prev_reg;
	assign word_done  = debug_serial_clock_rise & (bit_cnt_reg == `DTP_SER_LAST);

	always @(posedge ref_clk_i) begin
		if (ser_hold) begin
			rx_sh_reg          <= 8'h00;
			tx_sh_reg          <= 8'h00;
			tx_hold_reg        <= 8'h00;
			rx_hold_reg        <= 8'h00;
			rx_hold_v_reg      <= 1'b0;
			bit_cnt_reg        <= 3'h0;
			debug_serial_clock_prev_reg     <= 1'b0;
			debug_serial_out_o <= 1'b0;
			dbg_tx_ready_o     <= 1'b1;
			dbg_rx_overrun_o   <= 1'b0;
		end else begin
			debug_serial_clock_prev_reg <= debug_serial_clock_lvl;
			if (dbg_tx_valid_i && dbg_tx_ready_o) begin
				tx_hold_reg    <= dbg_tx_data_i;
				dbg_tx_ready_o <= 1'b0;
			end
			if (debug_serial_clock_rise) begin
				rx_sh_reg          <= {rx_sh_reg[6:0], dsi_lvl};
				debug_serial_out_o <= tx_sh_reg[7];
				tx_sh_reg          <= {tx_sh_reg[6:0], 1'b0};
				bit_cnt_reg        <= bit_cnt_reg + 3'h1;
			end
			if (word_done) begin
				// idle response shifts zeros if none queued
				tx_sh_reg <= dbg_tx_ready_o ? 8'h00 : tx_hold_reg;
				if (!dbg_tx_ready_o) begin
					dbg_tx_ready_o <= 1'b1;
				end
			end
			// a word waits here while the buffer is full
			if (word_done) begin
				rx_hold_reg   <= {rx_sh_reg[6:0], dsi_lvl};
				rx_hold_v_reg <= 1'b1;
				if (rx_hold_v_reg && !buf_in_ready) begin
					dbg_rx_overrun_o <= 1'b1;
				end
			end else if (rx_hold_v_reg && buf_in_ready) begin
				rx_hold_v_reg <= 1'b0;
			end
		end
	end

	dtp_pair_buf #(
		.W(`DTP_SER_W)
	) u_rx_buf (
		.ref_clk_i   (ref_clk_i),
		.srst_i      (ser_hold),
		.in_data_i   (rx_hold_reg),
		.in_valid_i  (rx_hold_v_reg),
		.in_ready_o  (buf_in_ready),
		.out_data_o  (dbg_rx_data_o),
		.out_valid_o (dbg_rx_valid_o),
		.out_ready_i (dbg_rx_ready_i)
	);

	// ********************************
	// breakpoint
	// ********************************
	reg breakpoint_request_prev_reg;
	reg breakpoint_request_pend_reg;

	always @(posedge ref_clk_i) begin
		if (srst_i) begin
			breakpoint_request_prev_reg <= 1'b0;
			breakpoint_request_pend_reg <= 1'b0;
			core_halt_o   <= 1'b0;
			debug_irq_o   <= 1'b0;
		end else begin
			breakpoint_request_prev_reg <= breakpoint_request_lvl;
			debug_irq_o   <= 1'b0;
			// new request wins over consuming the old one
			if (breakpoint_request_lvl && !breakpoint_request_prev_reg) begin
				breakpoint_request_pend_reg <= 1'b1;
			end else if (core_instr_done_i) begin
				breakpoint_request_pend_reg <= 1'b0;
			end
			if (breakpoint_request_pend_reg && core_instr_done_i) begin
				if (breakpoint_disable_i) begin
					debug_irq_o <= 1'b1;
				end else begin
					core_halt_o <= 1'b1;
				end
			end else if (core_resume_i) begin
				core_halt_o <= 1'b0;
			end
		end
	end

	// ********************************
	// trace outputs
	// ********************************
	reg  [1:0] phase_reg;
	reg        started_reg;
	wire [3:0] pst_val;
	wire [3:0] dd_val;
	wire       trace_run;

	assign pst_val   = core_halt_o ? `DTP_PST_HALT : core_status_i;
	assign dd_val    = core_halt_o ? `DTP_PST_HALT : core_ddata_i;
	assign trace_run = started_reg & ~trace_quiesce_i;

	always @(posedge ref_clk_i) begin
		if (srst_i) begin
			phase_reg           <= `DTP_TRC_PH_LOAD;
			started_reg         <= 1'b0;
			processor_status_o  <= 4'h0;
			debug_data_out_o    <= 4'h0;
			status_debug_data_o <= 8'h00;
			all_status_and_o    <= 1'b0;
			status_clock_o      <= 1'b0;
		end else begin
			phase_reg <= phase_reg + 2'h1;
			// start at first C, D or F
			if (core_status_i == `DTP_PST_START_C ||
				core_status_i == `DTP_PST_START_D ||
				core_status_i == `DTP_PST_HALT) begin
				started_reg <= 1'b1;
			end
			// status sampled on clock, not bus
			if (trace_run && phase_reg == `DTP_TRC_PH_LOAD) begin
				processor_status_o  <= pst_val;
				debug_data_out_o    <= dd_val;
				status_debug_data_o <= {pst_val, dd_val};
				all_status_and_o    <= &pst_val;
			end
			// rise at mid-point of valid data
			if (!trace_run) begin
				status_clock_o <= 1'b0;
			end else if (phase_reg == `DTP_TRC_PH_MID) begin
				status_clock_o <= 1'b1;
			end else if (phase_reg == `DTP_TRC_PH_LOAD) begin
				status_clock_o <= 1'b0;
			end
		end
	end
endmodule

/* File: logic/dtp_consts.vh */
// constants for the debug and trace port
`ifndef DTP_CONSTS_VH
`define DTP_CONSTS_VH

// scan controller state codes
`define DTP_TAP_RESET     4'hF
`define DTP_TAP_IDLE      4'hC
`define DTP_TAP_SEL_DR    4'h7
`define DTP_TAP_CAP_DR    4'h6
`define DTP_TAP_SHIFT_DR  4'h2
`define DTP_TAP_EXIT1_DR  4'h1
`define DTP_TAP_PAUSE_DR  4'h3
`define DTP_TAP_EXIT2_DR  4'h0
`define DTP_TAP_UPD_DR    4'h5
`define DTP_TAP_SEL_IR    4'h4
`define DTP_TAP_CAP_IR    4'hE
`define DTP_TAP_SHIFT_IR  4'hA
`define DTP_TAP_EXIT1_IR  4'h9
`define DTP_TAP_PAUSE_IR  4'hB
`define DTP_TAP_EXIT2_IR  4'h8
`define DTP_TAP_UPD_IR    4'hD

// instruction register
`define DTP_IR_W          4
`define DTP_IR_CAPTURE    4'h1
`define DTP_IR_BYPASS     4'hF
`define DTP_IR_STATUS     4'h2

// processor status codes
`define DTP_PST_HALT      4'hF
`define DTP_PST_START_C   4'hC
`define DTP_PST_START_D   4'hD

// serial debug word
`define DTP_SER_W         8
`define DTP_SER_LAST      3'h7

// trace clock: one status period spans four reference cycles
`define DTP_TRC_PH_W      2
`define DTP_TRC_PH_LOAD   2'h0
`define DTP_TRC_PH_MID    2'h2

`endif

/* File: logic/dtp_sync3.v */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module dtp_sync3 #(
	parameter W = 1
) (
	// clock and reset
	input  wire         ref_clk_i,
	input  wire         srst_i,
	// pins and filtered levels
	input  wire [W-1:0] pin_i,
	output reg  [W-1:0] level_o
);
	reg [W-1:0] s1_reg;
	reg [W-1:0] s2_reg;
	reg [W-1:0] s3_reg;
	integer     k;

	// first stage feeds only the second
	// stages keep running under reset so a strap is seen while it is held
	always @(posedge ref_clk_i) begin
		s1_reg <= pin_i;
		s2_reg <= s1_reg;
		s3_reg <= s2_reg;
		if (srst_i) begin
			// filter skipped in reset: pins are static then
			level_o <= s3_reg;
		end else begin
			// a level counts once two later stages agree
			for (k = 0; k < W; k = k + 1) begin
				if (s2_reg[k] == s3_reg[k]) begin
					level_o[k] <= s3_reg[k];
				end
			end
		end
	end
endmodule

/* File: logic/dtp_pair_buf.v */
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
module dtp_pair_buf #(
	parameter W = 8
) (
	// clock and reset
	input  wire         ref_clk_i,
	input  wire         srst_i,
	// fill side
	input  wire [W-1:0] in_data_i,
	input  wire         in_valid_i,
	output wire         in_ready_o,
	// drain side
	output reg  [W-1:0] out_data_o,
	output reg          out_valid_o,
	input  wire         out_ready_i
);
	reg [W-1:0] skid_reg;
	reg         skid_v_reg;
	wire        push;

	// full when the second entry is occupied
	assign in_ready_o = ~skid_v_reg;
	assign push       = in_valid_i & ~skid_v_reg;

	always @(posedge ref_clk_i) begin
		if (srst_i) begin
			out_data_o  <= {W{1'b0}};
			out_valid_o <= 1'b0;
			skid_reg    <= {W{1'b0}};
			skid_v_reg  <= 1'b0;
		end else if (!out_valid_o || out_ready_i) begin
			if (skid_v_reg) begin
				out_data_o  <= skid_reg;
				out_valid_o <= 1'b1;
				skid_v_reg  <= 1'b0;
			end else if (push) begin
				out_data_o  <= in_data_i;
				out_valid_o <= 1'b1;
			end else begin
				out_valid_o <= 1'b0;
			end
		end else if (push) begin
			skid_reg   <= in_data_i;
			skid_v_reg <= 1'b1;
		end
	end
endmodule

/* File: dv/dtp_monitor.sv */
// assertion checker for the debug and trace port
`timescale 1ns/1ns
module dtp_monitor (
	// clock and reset
	input wire       ref_clk_i,
	input wire       srst_i,
	// scan port
	input wire       scan_mode_o,
	input wire       test_reset_n_i,
	input wire       test_clock_i,
	input wire       test_data_out_o,
	input wire       test_data_out_oe_o,
	// serial debug
	input wire       debug_serial_clock_i,
	input wire       debug_serial_out_o,
	// breakpoint
	input wire       breakpoint_disable_i,
	input wire       core_instr_done_i,
	input wire       core_halt_o,
	input wire       debug_irq_o,
	// trace
	input wire [3:0] core_status_i,
	input wire       trace_quiesce_i,
	input wire [3:0] processor_status_o,
	input wire [7:0] status_debug_data_o,
	input wire       all_status_and_o,
	input wire       status_clock_o
);
	reg seen_start_reg;

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);

	// start codes seen since reset; the trace clock may not run before
	always @(posedge ref_clk_i) begin
		if (srst_i)
			seen_start_reg <= 1'b0;
		else if (core_status_i == 4'hC || core_status_i == 4'hD ||
			core_status_i == 4'hF)
			seen_start_reg <= 1'b1;
	end

	a_strap_kept: assert property (
		!$past(srst_i) |-> $stable(scan_mode_o))
		else $error("mode strap changed outside reset");
	a_trst_clear: assert property (
		!test_reset_n_i |=> !test_data_out_oe_o)
		else $error("scan output driven under test reset");
	a_oe_scan_only: assert property (
		test_data_out_oe_o |-> scan_mode_o)
		else $error("scan output driven in debug mode");
	a_tdo_on_fall: assert property (
		($changed(test_data_out_o) || $changed(test_data_out_oe_o)) &&
		test_reset_n_i |-> !test_clock_i && !$past(test_clock_i, 2))
		else $error("scan output moved while test clock high");
	a_ser_out_rise: assert property (
		$changed(debug_serial_out_o) |-> debug_serial_clock_i)
		else $error("serial output moved with serial clock low");
	a_halt_cause: assert property (
		$rose(core_halt_o) |->
		$past(core_instr_done_i) && !$past(breakpoint_disable_i))
		else $error("halt without completed instruction");
	a_halt_shows_f: assert property (
		core_halt_o && !trace_quiesce_i |-> ##[0:8]
		(processor_status_o == 4'hF && status_debug_data_o == 8'hFF))
		else $error("halt not shown on trace");
	a_irq_pulse: assert property (
		debug_irq_o |-> ($past(core_instr_done_i) &&
		breakpoint_disable_i) ##1 !debug_irq_o)
		else $error("debug interrupt pulse wrong");
	a_mid_rise: assert property (
		$rose(status_clock_o) |->
		$stable(status_debug_data_o) ##1 $stable(status_debug_data_o))
		else $error("trace data moved near clock rise");
	a_quiesce_frz: assert property (
		trace_quiesce_i [*6] |->
		$stable(status_clock_o) && $stable(status_debug_data_o))
		else $error("trace toggled while quiesced");
	a_start_code: assert property (
		status_clock_o |-> seen_start_reg)
		else $error("trace clock before start code");
	a_all_and: assert property (
		all_status_and_o == &processor_status_o)
		else $error("all-status output not AND of status");
endmodule

/* File: dv/dtp_host_model.sv */
// development system model on the serial debug link
`timescale 1ns/1ns
module dtp_host_model (
	// serial debug link
	output reg  debug_serial_clock_o,
	output reg  debug_serial_in_o,
	input  wire debug_serial_out_i,
	// trace clock, watched to resynchronise
	input  wire status_clock_i
);
	initial begin
		debug_serial_clock_o = 1'b0;
		debug_serial_in_o = 1'b0;
	end

	// 80 ns period, five status periods
	task xfer(input [7:0] w, output [7:0] r);
		integer k;
		begin
			#3;
			for (k = 7; k >= 0; k = k - 1) begin
				debug_serial_in_o = w[k];
				#40 debug_serial_clock_o = 1'b1;
				#40 debug_serial_clock_o = 1'b0;
				r[k] = debug_serial_out_i;
			end
			// idle line must not look like a held bit
			debug_serial_in_o = ~debug_serial_in_o;
		end
	endtask

	task resync(output ok);
		integer k;
		begin
			ok = 1'b0;
			for (k = 0; k < 40 && !ok; k = k + 1)
				#2 ok = status_clock_i;
		end
	endtask
endmodule

/* File: dv/tb.sv */
// self-checking bench for the debug and trace port
`timescale 1ns/1ns
module tb;
	reg        ref_clk_i, srst_i, scan_mode_strap_i, test_reset_n_i;
	reg        test_clock_i, test_mode_sel_i, test_data_in_i;
	reg        dbg_rx_ready_i, dbg_tx_valid_i, breakpoint_request_i;
	reg        breakpoint_disable_i, core_instr_done_i, core_resume_i;
	reg        trace_quiesce_i, ok;
	reg  [7:0] dbg_tx_data_i, v, w;
	reg  [7:0] wq [0:3];
	reg  [3:0] core_status_i, core_ddata_i;
	reg [31:0] rnd;
	wire       scan_mode_o, test_data_out_o, test_data_out_oe_o;
	wire       debug_serial_clock_i, debug_serial_in_i, debug_serial_out_o;
	wire       dbg_rx_valid_o, dbg_rx_overrun_o, dbg_tx_ready_o;
	wire       core_halt_o, debug_irq_o, all_status_and_o, status_clock_o;
	wire [7:0] dbg_rx_data_o, status_debug_data_o;
	wire [3:0] processor_status_o, debug_data_out_o;
	integer    seed, fail_count, tests_run, i, seen;

	dtp_debug_port DUT (.*);
	dtp_host_model u_host (
		.debug_serial_clock_o(debug_serial_clock_i),
		.debug_serial_in_o   (debug_serial_in_i),
		.debug_serial_out_i  (debug_serial_out_o),
		.status_clock_i      (status_clock_o)
	);

	initial begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end

	// ****
	// helpers
	// ****
	function [7:0] exp_sdd(input [3:0] st, input [3:0] dd, input h);
		exp_sdd = h ? 8'hFF : {st, dd};
	endfunction
	task chk(input [7:0] got, input [7:0] exp);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task wrap_up;
		begin
			$display("checks %0d mismatches %0d", tests_run, fail_count);
			if (fail_count == 0 && tests_run > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	// a bounded wait that ran out ends the run
	task bound(input [7:0] got, input [7:0] exp);
		begin
			chk(got, exp);
			if (got !== exp)
				wrap_up;
		end
	endtask
	task cyc(input integer n);
		repeat (n) @(posedge ref_clk_i);
	endtask
	task rst(input s);
		begin
			srst_i <= 1'b1;
			scan_mode_strap_i <= s;
			cyc(10);
			chk(scan_mode_o, s);
			chk(dbg_tx_ready_o, 1);
			srst_i <= 1'b0;
			cyc(4);
		end
	endtask
	// one test clock period, 80 ns low and 40 ns high
	task tck(input m, input d);
		begin
			test_mode_sel_i <= m;
			test_data_in_i <= d;
			cyc(10);
			test_clock_i <= 1'b1;
			cyc(10);
			test_clock_i <= 1'b0;
			cyc(10);
		end
	endtask

	initial begin
		#300000;
		fail_count = fail_count + 1;
		wrap_up;
	end

	// ****
	// main sequence
	// ****
	initial begin
		seed = 24073;
		fail_count = 0;
		tests_run = 0;
		{scan_mode_strap_i, test_clock_i, test_mode_sel_i, test_data_in_i,
		 dbg_rx_ready_i, dbg_tx_valid_i, breakpoint_request_i, core_resume_i,
		 breakpoint_disable_i, core_instr_done_i, trace_quiesce_i,
		 dbg_tx_data_i, core_status_i, core_ddata_i} = 27'h0;
		srst_i = 1'b1;
		test_reset_n_i = 1'b1;
		rst(1'b1);
		for (i = 0; i < 9; i = i + 1)
			tck(i < 5 || i == 6 || i == 7, 1'b0);
		chk(test_data_out_oe_o, 0);
		tck(1'b0, 1'b0);
		w = 8'h02;
		for (i = 0; i < 4; i = i + 1) begin
			chk(test_data_out_oe_o, 1);
			chk(test_data_out_o, i == 0);
			tck(i == 3, w[i]);
		end
		chk(test_data_out_oe_o, 0);
		for (i = 0; i < 4; i = i + 1)
			tck(i < 2, 1'b0);
		chk(test_data_out_o, 1);
		test_reset_n_i <= 1'b0;
		cyc(2);
		chk(test_data_out_oe_o, 0);
		test_reset_n_i <= 1'b1;
		$display("scan test done");
		rst(1'b0);
		seen = 0;
		for (i = 0; i < 20; i = i + 1) begin
			seen = seen | status_clock_o;
			@(posedge ref_clk_i);
		end
		chk(seen, 0);
		core_status_i <= 4'hC;
		for (i = 0; i < 12 && status_clock_o !== 1'b1; i = i + 1)
			@(posedge ref_clk_i);
		bound(status_clock_o, 1);
		for (i = 0; i < 8; i = i + 1) begin
			rnd = $random(seed);
			core_status_i <= i ? rnd[3:0] : 4'hF;
			core_ddata_i <= rnd[7:4];
			cyc(12);
			w = exp_sdd(core_status_i, core_ddata_i, 1'b0);
			chk(status_debug_data_o, w);
			chk(debug_data_out_o, core_ddata_i);
			chk(all_status_and_o, &core_status_i);
		end
		trace_quiesce_i <= 1'b1;
		cyc(12);
		w = status_debug_data_o;
		core_status_i <= ~core_status_i;
		core_ddata_i <= ~core_ddata_i;
		cyc(20);
		chk(status_debug_data_o, w);
		trace_quiesce_i <= 1'b0;
		u_host.resync(ok);
		bound(ok, 1);
		cyc(12);
		w = exp_sdd(core_status_i, core_ddata_i, 1'b0);
		chk(status_debug_data_o, w);
		$display("trace test done");
		for (i = 0; i < 2; i = i + 1) begin
			breakpoint_disable_i <= i[0];
			breakpoint_request_i <= 1'b1;
			cyc(8);
			core_instr_done_i <= 1'b1;
			@(posedge ref_clk_i);
			core_instr_done_i <= 1'b0;
			seen = 0;
			repeat (8) begin
				@(posedge ref_clk_i);
				seen = seen | debug_irq_o;
			end
			chk(seen, i);
			chk(core_halt_o, !i);
			cyc(12);
			w = exp_sdd(core_status_i, core_ddata_i, !i);
			chk(status_debug_data_o, w);
			core_resume_i <= 1'b1;
			breakpoint_request_i <= 1'b0;
			@(posedge ref_clk_i);
			core_resume_i <= 1'b0;
			cyc(3);
			chk(core_halt_o, 0);
		end
		$display("breakpoint test done");
		rnd = $random(seed);
		v = rnd[7:0];
		chk(dbg_tx_ready_o, 1);
		dbg_tx_data_i <= v;
		dbg_tx_valid_i <= 1'b1;
		@(posedge ref_clk_i);
		dbg_tx_valid_i <= 1'b0;
		// receiver stalls: two entries fill, word four overwrites the hold
		for (i = 0; i < 4; i = i + 1) begin
			rnd = $random(seed);
			wq[i] = rnd[7:0];
			u_host.xfer(wq[i], w);
			chk(w, i == 1 ? v : 8'h00);
			cyc(4);
			chk(dbg_rx_overrun_o, i == 3);
		end
		for (i = 0; i < 3; i = i + 1) begin
			bound(dbg_rx_valid_o, 1);
			chk(dbg_rx_data_o, wq[i + (i == 2)]);
			dbg_rx_ready_i <= 1'b1;
			@(posedge ref_clk_i);
			dbg_rx_ready_i <= 1'b0;
			cyc(3);
		end
		chk(dbg_rx_valid_o, 0);
		$display("serial test done");
		wrap_up;
	end
endmodule

bind dtp_debug_port dtp_monitor u_mon (.*);
